// ===== bench/touch_adc_host_model.sv
`timescale 1ns/10ps
// ============================================================
// Host side: select, serial clock, command bits, comparator model
module touch_adc_host_model (
    input  wire logic        clk_sys,
    input  wire logic        serial_result_out,
    input  wire logic        serial_result_oe,
    input  wire logic        busy_out,
    input  wire logic        track_hold_acquire,
    input  wire logic [11:0] dac_trial_code,
    output logic             cs_b,
    output logic             serial_conversion_clock,
    output logic             serial_cmd_in,
    output logic             cmp_high
);
    logic [11:0] target;
    logic        dout_line;

    // Released line shows the inverse, so a stale bit never matches
    assign dout_line = serial_result_oe ? serial_result_out : ~serial_result_out;
    assign cmp_high  = (target >= dac_trial_code);

    initial begin
        cs_b = 1'b1;
        serial_conversion_clock = 1'b0;
        serial_cmd_in = 1'b0;
        target = 12'h000;
    end

    // ============================================================
    // One serial clock cycle, sampled late in the low half
    task automatic sclk_cycle(input logic cmd, output logic sd, output logic sb,
                              output logic sa);
        @(negedge clk_sys);
        serial_cmd_in = cmd;
        serial_conversion_clock = 1'b1;
        repeat (3) @(negedge clk_sys);
        serial_conversion_clock = 1'b0;
        repeat (3) @(negedge clk_sys);
        sd = dout_line;
        sb = busy_out;
        sa = track_hold_acquire;
    endtask

    // Optional idle zeros, start bit, seven control bits, then zeros
    task automatic frame(input logic [6:0] ctrl, input logic [11:0] tgt, input int lead,
                         input int falls, output logic [23:1] d, output logic [23:1] b,
                         output logic [23:1] a);
        logic [7:0] word;
        logic       x;
        logic       y;
        logic       z;
        word = {1'b1, ctrl};
        target = tgt;
        d = '0;
        b = '0;
        a = '0;
        @(negedge clk_sys);
        cs_b = 1'b0;
        repeat (lead) sclk_cycle(1'b0, x, y, z);
        for (int k = 1; k <= falls; k++) begin
            sclk_cycle((k <= 8) ? word[8-k] : 1'b0, d[k], b[k], a[k]);
        end
    endtask

    task automatic deselect();
        @(negedge clk_sys);
        cs_b = 1'b1;
    endtask
endmodule

// ===== bench/touch_adc_serial_port_test.sv
`timescale 1ns/10ps
module touch_adc_serial_port_test;
    import touch_adc_pkg::*;
    logic        clk_sys, rst_b, cs_b, serial_conversion_clock, serial_cmd_in, cmp_high;
    logic        pen_touch_detect, serial_result_out, serial_result_oe, busy_out, busy_oe;
    logic        pen_touch_alert_n, pen_touch_alert_oe, track_hold_acquire;
    logic        result_valid, result_ready, alert_line;
    logic [11:0] dac_trial_code;
    ctrl_word_t  ctrl_word;
    result_t     result_data;
    logic [23:1] d, b, a;
    int          n_mismatch, checks_done;

    // Pull-up on the open-drain alert
    assign alert_line = pen_touch_alert_oe ? pen_touch_alert_n : 1'b1;

    touch_adc_serial_port u_touch_adc_serial_port (.clk_sys, .rst_b, .cs_b,
        .serial_conversion_clock, .serial_cmd_in, .cmp_high, .pen_touch_detect,
        .serial_result_out, .serial_result_oe, .busy_out, .busy_oe, .pen_touch_alert_n,
        .pen_touch_alert_oe, .track_hold_acquire, .dac_trial_code, .ctrl_word,
        .result_valid, .result_ready, .result_data);
    touch_adc_host_model u_touch_adc_host_model (.clk_sys, .serial_result_out,
        .serial_result_oe, .busy_out, .track_hold_acquire, .dac_trial_code, .cs_b,
        .serial_conversion_clock, .serial_cmd_in, .cmp_high);

    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;

    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ============================================================
    // One conversion, result bits judged from the MSB fall on, busy and acquisition on every fall after the start bit
    task automatic run(input logic [6:0] ctrl, input logic [11:0] tgt, input int lead);
        int          nb;
        logic [11:0] code;
        nb = ctrl[3] ? 8 : 12;
        code = ctrl[3] ? {4'h0, tgt[11:4]} : tgt;
        u_touch_adc_host_model.frame(ctrl, tgt, lead, nb + 11, d, b, a);
        for (int k = 1; k <= nb + 11; k++) begin
            if (k >= 9) check(13'((k < 9 + nb) ? code[nb+8-k] : 1'b0), 13'(d[k]));
            check(13'(b[k]), 13'(k == 8));
            check(13'(a[k]), 13'(k >= 5 && k <= 7));
        end
        check(13'(ctrl_word), 13'(ctrl));
        check(13'(dac_trial_code), 13'(ctrl[3] ? {tgt[11:4], 4'h0} : tgt));
        check(13'({serial_result_oe, busy_oe}), 13'h0003);
    endtask

    task automatic pop(input result_t exp);
        int i;
        for (i = 0; i < 50 && result_valid !== 1'b1; i++) @(negedge clk_sys);
        if (i == 50) begin
            $display("ERROR %0t: result never offered", $time);
            n_mismatch++;
            stop_test();
        end else begin
            check(result_data, exp);
            result_ready = 1'b1;
            @(negedge clk_sys);
            result_ready = 1'b0;
        end
    endtask

    task automatic t_full_and_pen();
        run(7'h54, 12'ha5c, 0);
        pop({1'b0, 12'ha5c});
        pen_touch_detect = 1'b1;
        repeat (3) @(negedge clk_sys);
        check(13'(alert_line), 13'h0000);
        $display("test full_and_pen done");
    endtask

    task automatic t_short_lead();
        run(7'h3b, 12'h3c7, 2);
        pop({1'b1, 12'h03c});
        repeat (3) @(negedge clk_sys);
        check(13'(alert_line), 13'h0001);
        pen_touch_detect = 1'b0;
        $display("test short_lead done");
    endtask

    task automatic t_deselect();
        logic x;
        u_touch_adc_host_model.deselect();
        repeat (3) @(negedge clk_sys);
        check(13'({serial_result_oe, busy_oe}), 13'h0000);
        for (int k = 1; k <= 12; k++) u_touch_adc_host_model.sclk_cycle(1'b1, x, x, a[k]);
        check(13'({a[12:1], result_valid}), 13'h0000);
        u_touch_adc_host_model.frame(7'h54, 12'hfff, 0, 6, d, b, a);
        u_touch_adc_host_model.deselect();
        repeat (3) @(negedge clk_sys);
        check(13'({track_hold_acquire, result_valid}), 13'h0000);
        run(7'h54, 12'h001, 0);
        pop({1'b0, 12'h001});
        repeat (3) @(negedge clk_sys);
        check(13'(result_valid), 13'h0000);
        $display("test deselect done");
    endtask

    task automatic t_fifo();
        for (int i = 0; i < 16; i++) run(7'h08, {i[3:0], 8'h00}, 0);
        u_touch_adc_host_model.frame(7'h08, 12'h000, 0, 19, d, b, a);
        check(13'(a), 13'h0000);
        for (int i = 0; i < 16; i++) pop({1'b1, 4'h0, i[3:0], 4'h0});
        @(negedge clk_sys);
        check(13'(result_valid), 13'h0000);
        $display("test fifo done");
    endtask

    initial begin
        n_mismatch = 0;
        checks_done = 0;
        rst_b = 1'b0;
        pen_touch_detect = 1'b0;
        result_ready = 1'b0;
        repeat (12) @(negedge clk_sys);
        rst_b = 1'b1;
        t_full_and_pen();
        t_short_lead();
        t_deselect();
        t_fifo();
        stop_test();
    end
endmodule

// ===== verilog/result_fifo.sv
`timescale 1ns/10ps
module result_fifo #(
    parameter int unsigned WIDTH = 13,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW-1:0]    rd_ptr_inc;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             push;
    logic             pop;

    assign push       = in_valid & in_ready;
    assign pop        = out_valid & out_ready;
    assign rd_ptr_inc = rd_ptr_reg + 1'b1;

    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            in_ready   <= 1'b1;
            out_valid  <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_inc;
            end
            count_reg <= count_next;
            in_ready  <= (count_next != FULL_COUNT);
            out_valid <= (count_next != '0);
        end
    end

    // Head word is registered so the consumer sees flop outputs only
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            out_data <= '0;
        end else if (push && (count_reg == '0 || (pop && count_reg == (AW+1)'(1)))) begin
            out_data <= in_data;
        end else if (pop) begin
            out_data <= mem[rd_ptr_inc];
        end
    end

endmodule

// ===== verilog/touch_adc_pkg.sv
// ============================================================
// Behaviour
// - Each result bit leaves on the serial result output at a serial clock fall.
// - Serial result output floats whenever the device select is high.
// - Busy is a logic output that floats whenever the device select is high.
// - Host presents control bits; device samples them on serial clock rises.
// - Select is active low; low enables shifting and conversions; high ignores activity.
// - The host serial clock shifts data and is the only conversion clock.
// - Pen alert is open drain: pulls low when asserted, otherwise released.
// - Acquisition starts on the fifth serial clock fall after the start bit.
// - Acquisition lasts exactly three serial clock cycles, then hold and conversion.
// - Result goes out MSB first, remaining bits, then zero trailing bits.
// - Result code is straight unsigned binary, one step per reference/4096, or per reference/256 in 8-bit mode.
package touch_adc_pkg;

    // ============================================================
    // Serial frame timing, in serial clock falls after the start bit
    localparam logic [4:0]  FALL_ACQ_START = 5'h05;
    localparam logic [4:0]  ACQ_CYCLES     = 5'h03;
    localparam logic [4:0]  FALL_HOLD      = 5'h08;
    localparam logic [4:0]  FALL_MSB       = 5'h09;
    localparam logic [4:0]  BITS_FULL      = 5'h0c;
    localparam logic [4:0]  BITS_SHORT     = 5'h08;
    localparam logic [4:0]  TRAIL_ZEROS    = 5'h03;
    localparam logic [4:0]  FALL_RESET     = 5'h00;
    localparam logic [2:0]  CTRL_BITS      = 3'h7;
    localparam logic [2:0]  CTRL_CNT_RESET = 3'h0;

    // ============================================================
    // Converter codes and reset values
    localparam int unsigned RESULT_BITS    = 12;
    localparam int unsigned FIFO_DEPTH     = 16;
    localparam logic [11:0] SAR_MSB        = 12'h800;
    localparam logic [11:0] CODE_RESET     = 12'h000;
    localparam logic [1:0]  PD_ALERT_OFF   = 2'h3;

    typedef struct packed {
        logic [2:0] channel;
        logic       short_mode;
        logic       single_ended;
        logic [1:0] power_down;
    } ctrl_word_t;

    localparam ctrl_word_t CTRL_RESET = 7'h00;

    typedef struct packed {
        logic        short_mode;
        logic [11:0] code;
    } result_t;

    localparam result_t RESULT_RESET = 13'h0000;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_CMD  = 2'b01,
        PH_CONV = 2'b10
    } phase_t;

endpackage

// ===== verilog/touch_adc_serial_port.sv
`timescale 1ns/10ps
module touch_adc_serial_port (
    input  wire logic                    clk_sys,
    input  wire logic                    rst_b,
    input  wire logic                    cs_b,
    input  wire logic                    serial_conversion_clock,
    input  wire logic                    serial_cmd_in,
    input  wire logic                    cmp_high,
    input  wire logic                    pen_touch_detect,
    output logic                         serial_result_out,
    output logic                         serial_result_oe,
    output logic                         busy_out,
    output logic                         busy_oe,
    output logic                         pen_touch_alert_n,
    output logic                         pen_touch_alert_oe,
    output logic                         track_hold_acquire,
    output logic [11:0]                  dac_trial_code,
    output touch_adc_pkg::ctrl_word_t    ctrl_word,
    output logic                         result_valid,
    input  wire logic                    result_ready,
    output touch_adc_pkg::result_t       result_data
);
    import touch_adc_pkg::*;

    // ============================================================
    // Frame decoding
    function automatic logic [4:0] last_data_fall(input logic short_mode);
        last_data_fall = FALL_MSB + (short_mode ? BITS_SHORT : BITS_FULL) - 5'h01;
    endfunction

    function automatic logic [4:0] last_fall(input logic short_mode);
        last_fall = last_data_fall(short_mode) + TRAIL_ZEROS;
    endfunction

    phase_t      phase_reg;
    logic        sclk_prev_reg;
    logic [4:0]  fall_cnt_reg;
    logic [4:0]  fall_cnt_next;
    logic [2:0]  ctrl_cnt_reg;
    logic [5:0]  ctrl_shift_reg;
    logic [11:0] sar_ptr_reg;
    logic [11:0] code_decided;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        start_bit;
    logic        hold_fall;
    logic        conv_bit;
    logic        last_bit;
    logic        fifo_in_ready;
    logic        push_valid_reg;
    result_t     push_data_reg;
    logic        first_bit_reg;
    logic        dout_cause;

    // ============================================================
    // Serial clock edges, seen at the system clock
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= serial_conversion_clock;
        end
    end

    assign sclk_rise     = serial_conversion_clock & ~sclk_prev_reg;
    assign sclk_fall     = ~serial_conversion_clock & sclk_prev_reg;
    assign fall_cnt_next = fall_cnt_reg + 5'h01;
    // Full buffer refuses new frames so no finished result is ever dropped
    assign start_bit     = (phase_reg == PH_IDLE) && !cs_b && sclk_rise
                           && serial_cmd_in && fifo_in_ready;
    assign hold_fall     = (phase_reg == PH_CMD) && !cs_b && sclk_fall
                           && (fall_cnt_next == FALL_HOLD);
    assign conv_bit      = (phase_reg == PH_CONV) && !cs_b && sclk_fall
                           && (fall_cnt_next >= FALL_MSB)
                           && (fall_cnt_next <= last_data_fall(ctrl_word.short_mode));
    assign last_bit      = conv_bit
                           && (fall_cnt_next == last_data_fall(ctrl_word.short_mode));
    assign code_decided  = (dac_trial_code & ~sar_ptr_reg)
                           | (cmp_high ? sar_ptr_reg : CODE_RESET);
    assign dout_cause    = sclk_fall | cs_b;

    // ============================================================
    // Frame sequencer
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            phase_reg <= PH_IDLE;
        end else if (cs_b) begin
            phase_reg <= PH_IDLE;
        end else begin
            unique case (phase_reg)
                PH_IDLE: begin
                    if (start_bit) begin
                        phase_reg <= PH_CMD;
                    end
                end
                PH_CMD: begin
                    if (hold_fall) begin
                        phase_reg <= PH_CONV;
                    end
                end
                PH_CONV: begin
                    if (sclk_fall && fall_cnt_next == last_fall(ctrl_word.short_mode)) begin
                        phase_reg <= PH_IDLE;
                    end
                end
                default: begin
                    phase_reg <= PH_IDLE;
                end
            endcase
        end
    end

    // Serial clock falls since the start bit drive all conversion timing
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fall_cnt_reg <= FALL_RESET;
        end else if (cs_b || phase_reg == PH_IDLE) begin
            fall_cnt_reg <= FALL_RESET;
        end else if (sclk_fall) begin
            fall_cnt_reg <= fall_cnt_next;
        end
    end

    // ============================================================
    // Control word shifter
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_cnt_reg   <= CTRL_CNT_RESET;
            ctrl_shift_reg <= 6'h00;
            ctrl_word      <= CTRL_RESET;
        end else if (cs_b || start_bit) begin
            ctrl_cnt_reg <= CTRL_CNT_RESET;
        end else if (phase_reg == PH_CMD && sclk_rise && ctrl_cnt_reg < CTRL_BITS) begin
            ctrl_cnt_reg   <= ctrl_cnt_reg + 3'h1;
            ctrl_shift_reg <= {ctrl_shift_reg[4:0], serial_cmd_in};
            if (ctrl_cnt_reg == CTRL_BITS - 3'h1) begin
                ctrl_word <= {ctrl_shift_reg, serial_cmd_in};
            end
        end
    end

    // ============================================================
    // Track and hold window
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            track_hold_acquire <= 1'b0;
        end else if (cs_b) begin
            track_hold_acquire <= 1'b0;
        end else if (phase_reg == PH_CMD && sclk_fall) begin
            if (fall_cnt_next == FALL_ACQ_START) begin
                track_hold_acquire <= 1'b1;
            end else if (fall_cnt_next == FALL_ACQ_START + ACQ_CYCLES) begin
                track_hold_acquire <= 1'b0;
            end
        end
    end

    // ============================================================
    // Successive approximation, one decision per serial clock fall
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dac_trial_code <= CODE_RESET;
            sar_ptr_reg    <= CODE_RESET;
        end else if (hold_fall) begin
            dac_trial_code <= SAR_MSB;
            sar_ptr_reg    <= SAR_MSB;
        end else if (conv_bit) begin
            sar_ptr_reg <= sar_ptr_reg >> 1;
            if (last_bit) begin
                dac_trial_code <= code_decided;
            end else begin
                dac_trial_code <= code_decided | (sar_ptr_reg >> 1);
            end
        end
    end

    // ============================================================
    // Serial result and busy pins
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            serial_result_out <= 1'b0;
        end else if (cs_b) begin
            serial_result_out <= 1'b0;
        end else if (conv_bit) begin
            serial_result_out <= cmp_high;
        end else if (sclk_fall && phase_reg != PH_IDLE) begin
            serial_result_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            busy_out <= 1'b0;
        end else if (cs_b) begin
            busy_out <= 1'b0;
        end else if (hold_fall) begin
            busy_out <= 1'b1;
        end else if (conv_bit && fall_cnt_next == FALL_MSB) begin
            busy_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            serial_result_oe <= 1'b0;
            busy_oe          <= 1'b0;
        end else begin
            serial_result_oe <= !cs_b;
            busy_oe          <= !cs_b;
        end
    end

    // ============================================================
    // Pen alert, open drain; the panel switches are busy during a frame
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pen_touch_alert_n  <= 1'b0;
            pen_touch_alert_oe <= 1'b0;
        end else begin
            pen_touch_alert_n  <= 1'b0;
            pen_touch_alert_oe <= pen_touch_detect && phase_reg == PH_IDLE
                                  && ctrl_word.power_down != PD_ALERT_OFF;
        end
    end

    // ============================================================
    // Finished results into the buffer
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            push_valid_reg <= 1'b0;
            push_data_reg  <= RESULT_RESET;
            first_bit_reg  <= 1'b0;
        end else begin
            push_valid_reg <= last_bit;
            if (conv_bit && fall_cnt_next == FALL_MSB) begin
                first_bit_reg <= cmp_high;
            end
            if (last_bit) begin
                push_data_reg.short_mode <= ctrl_word.short_mode;
                push_data_reg.code       <= ctrl_word.short_mode
                                            ? {4'h0, code_decided[11:4]}
                                            : code_decided;
            end
        end
    end

    result_fifo #(
        .WIDTH ($bits(result_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_result_fifo (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .in_valid  (push_valid_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data_reg),
        .out_valid (result_valid),
        .out_ready (result_ready),
        .out_data  (result_data)
    );

    // ============================================================
    // Checks
    AST_DOUT_ON_FALL:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
        $changed(serial_result_out) |-> $past(dout_cause))
        else $error("Result bit changed without a serial clock fall");

    AST_DOUT_FLOAT:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
        cs_b |=> !serial_result_oe)
        else $error("Result output driven while deselected");

    AST_BUSY_FLOAT:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
        cs_b |=> !busy_oe && !busy_out)
        else $error("Busy driven while deselected");

    AST_CMD_SAMPLE:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
        (phase_reg == PH_CMD && !cs_b && sclk_rise && ctrl_cnt_reg < CTRL_BITS)
        |=> ctrl_shift_reg[0] == $past(serial_cmd_in))
        else $error("Command bit not taken on a rising edge");

    AST_DESELECT_IDLE:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
        cs_b |=> phase_reg == PH_IDLE && fall_cnt_reg == FALL_RESET)
        else $error("Frame kept running while deselected");

    AST_START_BIT:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
        (phase_reg == PH_IDLE && !cs_b && sclk_rise && serial_cmd_in && fifo_in_ready)
        |=> phase_reg == PH_CMD && ctrl_cnt_reg == CTRL_CNT_RESET)
        else $error("Start bit not recognised");

    AST_ACQ_START:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(track_hold_acquire) |-> fall_cnt_reg == FALL_ACQ_START)
        else $error("Acquisition did not open on the fifth fall");

    AST_ACQ_LENGTH:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
        ($fell(track_hold_acquire) && !cs_b)
        |-> fall_cnt_reg == FALL_HOLD && busy_out && dac_trial_code == SAR_MSB)
        else $error("Acquisition window not three cycles");

    AST_MSB_FIRST:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
        (conv_bit && fall_cnt_next == FALL_MSB) |=> serial_result_out == $past(cmp_high))
        else $error("First result bit is not the decided MSB");

    AST_TRAIL_ZERO:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
        (phase_reg == PH_CONV && fall_cnt_reg > last_data_fall(ctrl_word.short_mode))
        |-> !serial_result_out)
        else $error("Trailing bit not zero");

    AST_CODE_BINARY:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
        push_valid_reg |-> (push_data_reg.short_mode ? push_data_reg.code[7]
                                                     : push_data_reg.code[11]) == first_bit_reg)
        else $error("Result MSB differs from first serial bit");

    AST_BUSY_END:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
        ($fell(busy_out) && !$past(cs_b)) |-> fall_cnt_reg == FALL_MSB)
        else $error("Busy did not drop with the MSB");

    AST_ALERT_OPEN_DRAIN:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
        pen_touch_alert_oe |-> !pen_touch_alert_n && $past(pen_touch_detect))
        else $error("Pen alert driven high or without a touch");

endmodule
